/* File: plcr_pkg.sv */
/*
 * package for the root port link capability report: field layout, fixed codes
 * and maximum width codes.
 * assumes the surrounding configuration space decodes the device; plcr_link_cap decodes the function.
 */
// What this block does
// RULE1: bits 17:15 read as a fixed deep idle exit latency code of 7h, the maximum.
// RULE2: the deep idle latency code doubles per step from under 1 us at 000 to over 64 us at 111.
// RULE3: bits 14:12 read as a fixed standby exit latency code of 7h, the maximum.
// RULE4: the standby latency code doubles per step from under 64 ns at 000 to over 4 us at 111.
// RULE5: bits 11:10 read as 01, standby entry supported.
// RULE6: the port never starts standby entry itself but lets the downstream device do so.
// RULE7: bits 9:4 hold the six-bit maximum width code, x1, x4, x8 or x16.
// RULE8: ports 0,3,5,7 report x4, ports 2,6 report x8 and port 4 reports x16.
// RULE9: bits 3:0 read as 0001, 2.5 Gb/s.
// RULE10: merged ports are controlled through the lower-numbered port's registers.
// RULE11: the register sits at configuration offset 78h of function 0 of each root port.
// RULE12: bits 31:24 hold the port number, written once and then frozen.
// RULE13: writes to the read-only capability fields are ignored.
package plcr_pkg;
   // ==========================================================
   // register location
   localparam logic [7:0]  CAP_OFFSET      = 8'h78;
   localparam logic [2:0]  CAP_FUNCTION    = 3'h0;
   // ==========================================================
   // field positions
   localparam int          PORT_NUM_LSB    = 24;
   localparam int          DEEP_LAT_LSB    = 15;
   localparam int          STBY_LAT_LSB    = 12;
   localparam int          PM_SUP_LSB      = 10;
   localparam int          WIDTH_LSB       = 4;
   localparam int          SPEED_LSB       = 0;
   // ==========================================================
   // fixed codes
   localparam logic [2:0]  DEEP_LAT_CODE   = 3'h7;
   localparam logic [2:0]  STBY_LAT_CODE   = 3'h7;
   localparam logic [1:0]  PM_SUP_CODE     = 2'h1;
   localparam logic [3:0]  SPEED_CODE      = 4'h1;
   localparam logic [5:0]  WIDTH_X1        = 6'h01;
   localparam logic [5:0]  WIDTH_X4        = 6'h04;
   localparam logic [5:0]  WIDTH_X8        = 6'h08;
   localparam logic [5:0]  WIDTH_X16       = 6'h10;

   typedef struct packed {
      logic [7:0] port_number;
      logic [5:0] rsvd;
      logic [2:0] deep_idle_exit_latency;
      logic [2:0] standby_exit_latency;
      logic [1:0] active_power_mgmt_support;
      logic [5:0] max_link_width;
      logic [3:0] max_link_speed;
   } plcr_cap_t;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [2:0] func;
      logic [7:0] offset;
      logic [3:0] be;
      logic [31:0] wdata;
   } plcr_cfg_t;
endpackage : plcr_pkg

/* File: plcr_link_cap.sv */
/*
 * link capability report for one root port; PORT_ID selects the width default.
 * assumes a configuration access strobe of one cycle, already routed to this
 * device (merged links route to the lower port upstream of here).
 */
`timescale 1ns/1ps
module plcr_link_cap #(
   parameter logic [7:0] PORT_ID = 8'h00
) (
   // clock and reset
   input  wire logic               clk_in,
   input  wire logic               sys_rst_in,
   // configuration access
   input  wire plcr_pkg::plcr_cfg_t cfg_in,
   // merged with the port below: this port's registers are not answered
   input  wire logic               merged_upper_in,
   // read answer
   output logic                    rd_valid_out,
   output logic [31:0]             rd_data_out,
   // standby entry request from this port, never raised
   output logic                    standby_init_out
);
   // ==========================================================
   // access decode
   wire logic       offset_match;
   wire logic       func_match;
   wire logic       port_owns_access;
   wire logic       hit;
   wire logic       rd_hit;
   wire logic       wr_hit;
   wire logic       wr_pn;

   assign offset_match     = (cfg_in.offset == plcr_pkg::CAP_OFFSET); // see RULE11
   assign func_match       = (cfg_in.func == plcr_pkg::CAP_FUNCTION); // see RULE11
   // the upper half of a merged link stays silent, the lower port answers for both
   assign port_owns_access = !merged_upper_in;                        // see RULE10
   assign hit              = offset_match && func_match && port_owns_access;
   assign rd_hit           = cfg_in.rd && hit;
   assign wr_hit           = cfg_in.wr && hit;
   // only the top byte lane carries writable bits
   assign wr_pn            = wr_hit && cfg_in.be[3];

   // ==========================================================
   // maximum width default per port
   wire logic       port_is_x16;
   wire logic       port_is_x8;
   wire logic [5:0] width_dflt;

   assign port_is_x16 = (PORT_ID == 8'h04);
   assign port_is_x8  = (PORT_ID == 8'h02) || (PORT_ID == 8'h06);
   // every other port, port 1 included, falls back to x4
   assign width_dflt  = port_is_x16 ? plcr_pkg::WIDTH_X16 :
                        port_is_x8  ? plcr_pkg::WIDTH_X8  :
                                      plcr_pkg::WIDTH_X4; // see RULE8 see RULE7

   // ==========================================================
   // port number, written once after reset
   logic [7:0]      pn_r;
   logic [7:0]      pn_nxt;
   logic            pn_lock_r;
   logic            pn_lock_nxt;
   wire logic       pn_take;

   assign pn_take     = wr_pn && !pn_lock_r; // see RULE12
   assign pn_nxt      = pn_take ? cfg_in.wdata[plcr_pkg::PORT_NUM_LSB +: 8] : pn_r;
   assign pn_lock_nxt = pn_lock_r || pn_take;

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         pn_r      <= PORT_ID;
         pn_lock_r <= 1'b0;
      end
      else
      begin
         pn_r      <= pn_nxt;
         pn_lock_r <= pn_lock_nxt;
      end
   end

   // ==========================================================
   // register image
   plcr_pkg::plcr_cap_t cap;

   // fixed fields never take write data
   always_comb
   begin
      cap.port_number               = pn_r;
      cap.rsvd                      = 6'h00;
      cap.deep_idle_exit_latency    = plcr_pkg::DEEP_LAT_CODE; // see RULE1 see RULE2 see RULE13
      cap.standby_exit_latency      = plcr_pkg::STBY_LAT_CODE; // see RULE3 see RULE4
      cap.active_power_mgmt_support = plcr_pkg::PM_SUP_CODE;   // see RULE5
      cap.max_link_width            = width_dflt;
      cap.max_link_speed            = plcr_pkg::SPEED_CODE;    // see RULE9
   end

   assign standby_init_out = 1'b0; // see RULE6

   // ==========================================================
   // read answer, one cycle after the access
   logic            rd_valid_r;
   logic            rd_valid_nxt;
   logic [31:0]     rd_data_r;
   logic [31:0]     rd_data_nxt;

   assign rd_valid_nxt = rd_hit; // see RULE11
   // data is zero between answers so a stray strobe cannot show old contents
   assign rd_data_nxt  = rd_hit ? cap : 32'h0000_0000;

   always_ff @(posedge clk_in)
   begin
      if (sys_rst_in)
      begin
         rd_valid_r <= 1'b0;
         rd_data_r  <= 32'h0000_0000;
      end
      else
      begin
         rd_valid_r <= rd_valid_nxt;
         rd_data_r  <= rd_data_nxt;
      end
   end

   assign rd_valid_out = rd_valid_r;
   assign rd_data_out  = rd_data_r;

   // ==========================================================
   // checks: reset
   rst_quiet_a: assert property (@(posedge clk_in) // see RULE11
      sys_rst_in |=>
         (!rd_valid_out && (rd_data_out == 32'h0000_0000)))
      else $error("answer seen after reset");

   rst_pn_default_a: assert property (@(posedge clk_in) // see RULE12
      sys_rst_in |=>
         ((pn_r == PORT_ID) && !pn_lock_r))
      else $error("port number not back to its default");

   standby_rst_a: assert property (@(posedge clk_in) // see RULE6
      sys_rst_in |->
         !standby_init_out)
      else $error("standby request during reset");

   // ==========================================================
   // checks: fixed fields
   deep_lat_fixed_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE1
      rd_valid_out |->
         (rd_data_out[plcr_pkg::DEEP_LAT_LSB +: 3] == plcr_pkg::DEEP_LAT_CODE))
      else $error("deep idle latency code wrong");

   deep_lat_top_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE2
      rd_valid_out |->
         (&rd_data_out[plcr_pkg::DEEP_LAT_LSB +: 3]))
      else $error("deep idle latency below the top range");

   stby_lat_fixed_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE3
      rd_valid_out |->
         (rd_data_out[plcr_pkg::STBY_LAT_LSB +: 3] == plcr_pkg::STBY_LAT_CODE))
      else $error("standby latency code wrong");

   stby_lat_top_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE4
      rd_valid_out |->
         (&rd_data_out[plcr_pkg::STBY_LAT_LSB +: 3]))
      else $error("standby latency below the top range");

   pm_sup_fixed_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE5
      rd_valid_out |->
         (rd_data_out[plcr_pkg::PM_SUP_LSB +: 2] == plcr_pkg::PM_SUP_CODE))
      else $error("power management support code wrong");

   pm_sup_legal_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE5
      rd_valid_out |->
         (rd_data_out[plcr_pkg::PM_SUP_LSB +: 2] != 2'h2))
      else $error("reserved power management code read");

   speed_fixed_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE9
      rd_valid_out |->
         (rd_data_out[plcr_pkg::SPEED_LSB +: 4] == plcr_pkg::SPEED_CODE))
      else $error("speed code wrong");

   rsvd_zero_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE13
      rd_valid_out |->
         (rd_data_out[(plcr_pkg::DEEP_LAT_LSB + 3) +: 6] == 6'h00))
      else $error("reserved bits not zero");

   fixed_low_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE13
      rd_valid_out |->
         (rd_data_out[plcr_pkg::PORT_NUM_LSB - 1:0] ==
          {6'h00, plcr_pkg::DEEP_LAT_CODE, plcr_pkg::STBY_LAT_CODE,
           plcr_pkg::PM_SUP_CODE, width_dflt, plcr_pkg::SPEED_CODE}))
      else $error("read-only fields changed");

   // ==========================================================
   // checks: width
   width_code_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE8
      rd_valid_out |->
         (rd_data_out[plcr_pkg::WIDTH_LSB +: 6] == width_dflt))
      else $error("width default wrong for this port");

   width_onehot_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE7
      rd_valid_out |->
         $onehot(rd_data_out[plcr_pkg::WIDTH_LSB +: 6]))
      else $error("width code not one-hot");

   width_legal_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE7
      rd_valid_out |->
         ((rd_data_out[plcr_pkg::WIDTH_LSB +: 6] == plcr_pkg::WIDTH_X1) ||
          (rd_data_out[plcr_pkg::WIDTH_LSB +: 6] == plcr_pkg::WIDTH_X4) ||
          (rd_data_out[plcr_pkg::WIDTH_LSB +: 6] == plcr_pkg::WIDTH_X8) ||
          (rd_data_out[plcr_pkg::WIDTH_LSB +: 6] == plcr_pkg::WIDTH_X16)))
      else $error("reserved width code read");

   // ==========================================================
   // checks: standby entry
   no_standby_init_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE6
      1'b1 |->
         !standby_init_out)
      else $error("standby initiated");

   // ==========================================================
   // checks: answer timing
   read_timing_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE11
      rd_hit |=>
         rd_valid_out)
      else $error("read not answered");

   read_cause_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE11
      rd_valid_out |->
         $past(rd_hit))
      else $error("answer without a read");

   offset_miss_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE11
      (cfg_in.rd && !offset_match) |=>
         !rd_valid_out)
      else $error("other offset answered");

   func_miss_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE11
      (cfg_in.rd && !func_match) |=>
         !rd_valid_out)
      else $error("other function answered");

   write_silent_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE11
      !cfg_in.rd |=>
         !rd_valid_out)
      else $error("answer without a read strobe");

   answer_single_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE11
      (rd_valid_out && !rd_hit) |=>
         !rd_valid_out)
      else $error("answer stood too long");

   idle_data_zero_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE11
      !rd_valid_out |->
         (rd_data_out == 32'h0000_0000))
      else $error("read data not zero between answers");

   // ==========================================================
   // checks: merged links
   merged_quiet_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE10
      merged_upper_in |=>
         !rd_valid_out)
      else $error("merged port answered");

   merged_pn_kept_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE10
      merged_upper_in |=>
         $stable(pn_r))
      else $error("merged port took a write");

   merged_lock_kept_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE10
      merged_upper_in |=>
         $stable(pn_lock_r))
      else $error("merged port locked its number");

   // ==========================================================
   // checks: port number
   pn_frozen_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE12
      pn_lock_r |=>
         $stable(pn_r))
      else $error("port number changed");

   pn_first_write_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE12
      pn_take |=>
         ((pn_r == $past(cfg_in.wdata[plcr_pkg::PORT_NUM_LSB +: 8])) && pn_lock_r))
      else $error("first port number write lost");

   pn_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE12
      !pn_take |=>
         $stable(pn_r))
      else $error("port number moved without a write");

   pn_reads_back_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE12
      rd_valid_out |->
         (rd_data_out[plcr_pkg::PORT_NUM_LSB +: 8] == $past(pn_r)))
      else $error("port number read back wrong");

   pn_lane_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE12
      (wr_hit && !cfg_in.be[3]) |=>
         $stable(pn_r))
      else $error("port number written with its lane off");

   lock_sticky_a: assert property (@(posedge clk_in) disable iff (sys_rst_in) // see RULE12
      pn_lock_r |=>
         pn_lock_r)
      else $error("port number lock dropped");
endmodule : plcr_link_cap

/* File: tb.sv */
/*
 * self-checking bench for the port 6 link capability report.
 * assumes plcr_pkg is compiled first and the design answers reads one cycle late.
 */
`timescale 1ns/1ps
module tb;
   // ==========================================================
   // signals
   logic                clk_in;
   logic                sys_rst_in;
   logic                merged_upper_in;
   logic                rd_valid_out;
   logic                standby_init_out;
   logic [31:0]         rd_data_out;
   logic [31:0]         w1;
   logic [3:0]          wr_be;
   plcr_pkg::plcr_cfg_t cfg_in;
   logic [31:0]         exp_q[$];
   int                  n_errors = 0;
   int                  checked = 0;

   plcr_link_cap #(.PORT_ID(8'h06)) u_plcr_link_cap (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .cfg_in(cfg_in), .merged_upper_in(merged_upper_in), .rd_valid_out(rd_valid_out),
      .rd_data_out(rd_data_out), .standby_init_out(standby_init_out));

   initial
   begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end

   // ==========================================================
   // tasks
   function automatic logic [31:0] cap(input logic [7:0] pn);
      return {pn, 6'h00, 3'h7, 3'h7, 2'h1, 6'h08, 4'h1};
   endfunction : cap

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   task automatic acc(input logic rd, wr, mg, input logic [2:0] fn, input logic [7:0] off,
                      input logic [31:0] wd, input logic hit, input logic [31:0] exp);
      @(negedge clk_in);
      cfg_in          <= '{rd, wr, fn, off, wr_be, wd};
      merged_upper_in <= mg;
      if (hit)
         exp_q.push_back(exp);
   endtask : acc

   task automatic report_and_stop;
      $display("errors %0d, comparisons %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop

   // ==========================================================
   // output monitor
   always @(negedge clk_in)
   begin
      if (!sys_rst_in)
      begin
         cmp({31'h0, standby_init_out}, 32'h0);
         if (rd_valid_out === 1'b1 && exp_q.size() > 0)
            cmp(rd_data_out, exp_q.pop_front());
         else
         begin
            cmp({31'h0, rd_valid_out}, 32'h0);
            cmp(rd_data_out, 32'h0);
         end
      end
   end

   initial
   begin
      repeat (5000) @(posedge clk_in);
      n_errors++;
      report_and_stop();
   end

   // ==========================================================
   // main sequence
   initial
   begin
      cfg_in          = '0;
      merged_upper_in = 1'b0;
      sys_rst_in      = 1'b1;
      void'($urandom(43));
      w1 = $urandom;
      wr_be = 4'hF;
      repeat (16) @(posedge clk_in);
      @(negedge clk_in) sys_rst_in <= 1'b0;
      acc(1'b1, 1'b0, 1'b0, 3'h0, 8'h78, 32'h0, 1'b1, cap(8'h06));
      wr_be = 4'h7;
      acc(1'b0, 1'b1, 1'b0, 3'h0, 8'h78, w1, 1'b0, 32'h0);
      wr_be = 4'hF;
      acc(1'b0, 1'b1, 1'b1, 3'h0, 8'h78, w1, 1'b0, 32'h0);
      acc(1'b0, 1'b1, 1'b0, 3'h1, 8'h78, w1, 1'b0, 32'h0);
      acc(1'b1, 1'b0, 1'b0, 3'h0, 8'h78, 32'h0, 1'b1, cap(8'h06));
      acc(1'b0, 1'b1, 1'b0, 3'h0, 8'h78, w1, 1'b0, 32'h0);
      acc(1'b1, 1'b0, 1'b0, 3'h0, 8'h78, 32'h0, 1'b1, cap(w1[31:24]));
      acc(1'b0, 1'b1, 1'b0, 3'h0, 8'h78, ~w1, 1'b0, 32'h0);
      acc(1'b1, 1'b0, 1'b0, 3'h0, 8'h78, 32'h0, 1'b1, cap(w1[31:24]));
      acc(1'b1, 1'b0, 1'b0, 3'h1, 8'h78, 32'h0, 1'b0, 32'h0);
      acc(1'b1, 1'b0, 1'b0, 3'h0, 8'h7C, 32'h0, 1'b0, 32'h0);
      acc(1'b1, 1'b0, 1'b1, 3'h0, 8'h78, 32'h0, 1'b0, 32'h0);
      acc(1'b0, 1'b0, 1'b0, 3'h0, 8'h78, 32'h0, 1'b0, 32'h0);
      @(negedge clk_in) sys_rst_in <= 1'b1;
      repeat (3) @(negedge clk_in);
      sys_rst_in <= 1'b0;
      acc(1'b1, 1'b0, 1'b0, 3'h0, 8'h78, 32'h0, 1'b1, cap(8'h06));
      acc(1'b0, 1'b1, 1'b0, 3'h0, 8'h78, ~w1, 1'b0, 32'h0);
      acc(1'b1, 1'b0, 1'b0, 3'h0, 8'h78, 32'h0, 1'b1, cap(~w1[31:24]));
      acc(1'b0, 1'b0, 1'b0, 3'h0, 8'h78, 32'h0, 1'b0, 32'h0);
      repeat (4) @(negedge clk_in);
      cmp(exp_q.size(), 32'h0);
      report_and_stop();
   end
endmodule : tb
